// *** src/sdha_core.sv ***
// Purpose: ADMA read data path with block counting and response check
// Assumes: Card clock, command and DAT0 arrive from pins, clock is 40 MHz
// Notes:   Card data is taken serially on DAT0, MSB first, 32 bits a word
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "sdha_params.svh"

module sdha_core #(
    parameter int DEPTH = 4
) (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        desc_valid,
    input  wire logic [31:0] desc_data,
    output logic             desc_ready,
    output logic             dma_valid,
    input  wire logic        dma_ready,
    output logic      [31:0] dma_data,
    input  wire logic        sd_clk,
    input  wire logic        sd_cmd,
    input  wire logic        sd_dat0,
    output logic             fifo_clk_en,
    output logic             irq
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        sdha_pkg::sdha_state_t   st;
        logic [2:0]              clk_sy;
        logic [1:0]              cmd_sy;
        logic [1:0]              dat_sy;
        logic [12:0]             blk_size;
        logic [15:0]             blk_cnt;
        logic                    block_count_enable;
        logic                    adma2;
        logic [3:0]              wm;
        logic [5:0]              cmd_idx;
        logic [3:0]              stat;
        logic [3:0]              mask;
        logic                    last;
        logic [16:0]             left;
        logic [12:0]             in_blk;
        logic [4:0]              nbit;
        logic [31:0]             shift;
        logic [DEPTH-1:0][31:0]  mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [AW:0]             cnt;
        logic [31:0]             rdata;
    } sdha_core_t;

    sdha_core_t s_reg, s_next;
    sdha_pkg::sdha_desc_t desc;
    logic clk_rise;
    logic full;
    logic empty;
    logic push;
    logic pop;
    logic word_done;
    logic blk_done;
    logic ends_xfer;
    logic arm;
    logic resp_done;
    logic crc_err;
    logic idx_err;

    assign desc      = sdha_pkg::sdha_desc_t'(desc_data);
    assign clk_rise  = s_reg.clk_sy[1] && !s_reg.clk_sy[2];
    assign full      = s_reg.cnt == (AW+1)'(DEPTH);
    assign empty     = s_reg.cnt == '0;
    assign arm       = reg_wr && reg_addr == `SDHA_OFS_CMDCTL
                       && reg_wdata[`SDHA_CC_ARM];

    // Card side fills only while not full; bus side drains while not empty
    assign fifo_clk_en = s_reg.st != sdha_pkg::SDHA_IDLE && !full
                         && !empty;
    assign word_done = s_reg.st == sdha_pkg::SDHA_XFER && clk_rise && !full
                       && s_reg.nbit == 5'd31;
    assign push      = word_done;
    assign blk_done  = word_done && (s_reg.in_blk + 13'd4 >= s_reg.blk_size);
    // Block limit: counting ends at zero, a count of one always ends
    assign ends_xfer = blk_done && (s_reg.blk_cnt == 16'd1);
    // Watermark gates bus requests, the tail drains regardless
    assign dma_valid = !empty && (s_reg.cnt >= (AW+1)'(s_reg.wm)
                       || s_reg.st == sdha_pkg::SDHA_WTC);
    assign pop       = dma_valid && dma_ready;
    assign dma_data  = s_reg.mem[s_reg.rp];
    assign desc_ready = s_reg.st == sdha_pkg::SDHA_FETCH;
    assign irq       = |(s_reg.stat & s_reg.mask);
    assign reg_rdata = s_reg.rdata;

    // Next state of the whole data path
    always_comb begin
        s_next = s_reg;
        // Two flip-flop synchronisers, third stage for edge finding
        s_next.clk_sy = {s_reg.clk_sy[1:0], sd_clk};
        s_next.cmd_sy = {s_reg.cmd_sy[0], sd_cmd};
        s_next.dat_sy = {s_reg.dat_sy[0], sd_dat0};
        s_next.rdata = 32'h0;
        // Register writes
        if (reg_wr) begin
            unique case (reg_addr)
                `SDHA_OFS_BLOCK_ATTRIBUTES_REGISTER: begin
                    s_next.blk_size = reg_wdata[12:0];
                    s_next.blk_cnt = reg_wdata[31:16];
                end
                `SDHA_OFS_XFERCTL: begin
                    s_next.block_count_enable = reg_wdata[`SDHA_XC_BLOCK_COUNT_ENABLE];
                    s_next.adma2 = reg_wdata[`SDHA_XC_ADMA2];
                    s_next.wm = reg_wdata[`SDHA_XC_WM_LSB +: 4];
                end
                `SDHA_OFS_CMDCTL: s_next.cmd_idx = reg_wdata[5:0];
                `SDHA_OFS_INTERRUPT_STATUS_REGISTER: s_next.stat = s_reg.stat & ~reg_wdata[3:0];
                `SDHA_OFS_IRQMASK: s_next.mask = reg_wdata[3:0];
                default: ;
            endcase
        end
        // Register reads, data stand one cycle
        if (reg_rd) begin
            unique case (reg_addr)
                `SDHA_OFS_BLOCK_ATTRIBUTES_REGISTER:
                    s_next.rdata = {s_reg.blk_cnt, 3'h0, s_reg.blk_size};
                `SDHA_OFS_XFERCTL:
                    s_next.rdata = {20'h0, s_reg.wm, 5'h0, s_reg.adma2,
                                    s_reg.block_count_enable, 1'b0};
                `SDHA_OFS_CMDCTL: s_next.rdata = {26'h0, s_reg.cmd_idx};
                `SDHA_OFS_PRSSTATE: begin
                    s_next.rdata[`SDHA_PS_DAT0] = s_reg.dat_sy[1];
                    s_next.rdata[`SDHA_PS_DLA] =
                        s_reg.st != sdha_pkg::SDHA_IDLE;
                    s_next.rdata[`SDHA_PS_BUSY] = !s_reg.dat_sy[1];
                end
                `SDHA_OFS_INTERRUPT_STATUS_REGISTER: s_next.rdata = {28'h0, s_reg.stat};
                `SDHA_OFS_IRQMASK: s_next.rdata = {28'h0, s_reg.mask};
                `SDHA_OFS_FIFOLVL:
                    s_next.rdata = 32'(s_reg.cnt);
                default: s_next.rdata = 32'h0;
            endcase
        end
        // FIFO pointers and level
        if (push) begin
            s_next.mem[s_reg.wp] = {s_reg.shift[30:0], s_reg.dat_sy[1]};
            s_next.wp = (s_reg.wp == AW'(DEPTH - 1)) ? '0 : s_reg.wp + 1'b1;
        end
        if (pop) begin
            s_next.rp = (s_reg.rp == AW'(DEPTH - 1)) ? '0 : s_reg.rp + 1'b1;
        end
        s_next.cnt = s_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
        // Data path sequencing
        unique case (s_reg.st)
            sdha_pkg::SDHA_IDLE: begin
                if (reg_wr && reg_addr == `SDHA_OFS_XFERCTL
                    && reg_wdata[`SDHA_XC_START]) begin
                    s_next.st = sdha_pkg::SDHA_FETCH;
                    s_next.last = 1'b0;
                    s_next.in_blk = 13'h0;
                    s_next.nbit = 5'h0;
                end
            end
            sdha_pkg::SDHA_FETCH: begin
                if (desc_valid) begin
                    s_next.last = desc.last;
                    // Only TRANS moves data; NOP and LINK pass on
                    if (desc.valid && desc.act == sdha_pkg::SDHA_ACT_TRAN) begin
                        s_next.left = {1'b0, desc.len};
                        s_next.st = sdha_pkg::SDHA_XFER;
                    end else if (desc.last) begin
                        s_next.st = sdha_pkg::SDHA_WTC;
                    end
                end
            end
            sdha_pkg::SDHA_XFER: begin
                if (clk_rise && !full) begin
                    s_next.shift = {s_reg.shift[30:0], s_reg.dat_sy[1]};
                    s_next.nbit = s_reg.nbit + 5'd1;
                end
                if (word_done) begin
                    // A length of 1 to 4 is a single word
                    s_next.left = (s_reg.left <= `SDHA_WORD_BYTES) ? 17'h0
                                  : s_reg.left - `SDHA_WORD_BYTES;
                    s_next.in_blk = blk_done ? 13'h0 : s_reg.in_blk + 13'd4;
                    if (blk_done && s_reg.block_count_enable && s_reg.blk_cnt != 16'h0) begin
                        s_next.blk_cnt = s_reg.blk_cnt - 16'd1;
                    end
                    if (ends_xfer) begin
                        s_next.st = sdha_pkg::SDHA_WTC;
                    end else if (s_reg.left <= `SDHA_WORD_BYTES) begin
                        s_next.st = s_reg.last ? sdha_pkg::SDHA_WTC
                                    : sdha_pkg::SDHA_FETCH;
                    end
                end
            end
            sdha_pkg::SDHA_WTC: begin
                // Completion needs a drained FIFO and aligned block size
                if (empty && s_reg.blk_size[1:0] == 2'b00) begin
                    s_next.stat[`SDHA_IS_TC] = 1'b1;
                    s_next.st = sdha_pkg::SDHA_IDLE;
                end
            end
            default: s_next.st = sdha_pkg::SDHA_IDLE;
        endcase
        // Software abort leaves any stall
        if (reg_wr && reg_addr == `SDHA_OFS_XFERCTL
            && reg_wdata[`SDHA_XC_ABORT]) begin
            s_next.st = sdha_pkg::SDHA_IDLE;
            s_next.cnt = '0;
            s_next.rp = s_next.wp;
        end
        // Response events set after clears, so a set wins
        if (resp_done) begin
            s_next.stat[`SDHA_IS_RESP] = 1'b1;
        end
        if (crc_err) begin
            s_next.stat[`SDHA_IS_CRC] = 1'b1;
        end
        if (idx_err) begin
            s_next.stat[`SDHA_IS_IDX] = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '0;
            s_reg.blk_size <= 13'(`SDHA_RST_BLOCK_ATTRIBUTES_REGISTER);
            s_reg.blk_cnt <= 16'(`SDHA_RST_BLOCK_ATTRIBUTES_REGISTER >> 16);
            s_reg.wm <= `SDHA_RST_WM;
        end else begin
            s_reg <= s_next;
        end
    end

    // Response checker runs regardless of the data path state
    sdha_resp_chk u_chk (
        .clock     (clock),
        .rst_b     (rst_b),
        .bit_en    (clk_rise),
        .cmd_bit   (s_reg.cmd_sy[1]),
        .arm       (arm),
        .exp_index (s_reg.cmd_idx),
        .done      (resp_done),
        .crc_err   (crc_err),
        .idx_err   (idx_err)
    );

    a_tc_aligned: assert property (
        @(posedge clock) disable iff (!rst_b)
        $rose(s_reg.stat[`SDHA_IS_TC]) |-> $past(s_reg.blk_size[1:0]) == 2'b00
        && $past(empty))
        else $error("Transfer complete with unaligned block or data left");
    a_wtc_stall: assert property (
        @(posedge clock) disable iff (!rst_b)
        s_reg.st == sdha_pkg::SDHA_WTC && s_reg.blk_size[1:0] != 2'b00
        && !reg_wr |=> s_reg.st == sdha_pkg::SDHA_WTC)
        else $error("Unaligned read left the completion wait");
    a_count_one_end: assert property (
        @(posedge clock) disable iff (!rst_b)
        ends_xfer |=> s_reg.st == sdha_pkg::SDHA_WTC)
        else $error("Block count of one did not end transfer");
    a_blk_decrement: assert property (
        @(posedge clock) disable iff (!rst_b)
        blk_done && s_reg.block_count_enable && s_reg.blk_cnt != 16'h0 && !reg_wr
        |=> s_reg.blk_cnt == $past(s_reg.blk_cnt) - 16'd1)
        else $error("Block count did not drop after a block");
    a_no_push_full: assert property (
        @(posedge clock) disable iff (!rst_b)
        full |-> !push && !fifo_clk_en)
        else $error("FIFO clock ran or filled while full");
    a_empty_pause: assert property (
        @(posedge clock) disable iff (!rst_b)
        empty |-> !fifo_clk_en && !dma_valid)
        else $error("FIFO clock ran while empty");
    a_dat0_visible: assert property (
        @(posedge clock) disable iff (!rst_b)
        reg_rd && reg_addr == `SDHA_OFS_PRSSTATE
        |=> reg_rdata[`SDHA_PS_DAT0] == $past(s_reg.dat_sy[1]))
        else $error("Present state bit 24 is not the DAT0 level");
    a_short_one_word: assert property (
        @(posedge clock) disable iff (!rst_b)
        word_done && s_reg.left <= `SDHA_WORD_BYTES && !ends_xfer && !reg_wr
        |=> s_reg.st != sdha_pkg::SDHA_XFER)
        else $error("Short descriptor moved more than one word");
    a_crc_flag_set: assert property (
        @(posedge clock) disable iff (!rst_b)
        crc_err |=> s_reg.stat[`SDHA_IS_CRC])
        else $error("CRC mismatch not flagged");

    c_tc_done: cover property (@(posedge clock) disable iff (!rst_b)
        $rose(s_reg.stat[`SDHA_IS_TC]));
    c_resp_in_xfer: cover property (@(posedge clock) disable iff (!rst_b)
        resp_done && s_reg.st == sdha_pkg::SDHA_XFER);
    c_count_end: cover property (@(posedge clock) disable iff (!rst_b)
        ends_xfer && s_reg.block_count_enable);
    c_fifo_full: cover property (@(posedge clock) disable iff (!rst_b)
        full && s_reg.st == sdha_pkg::SDHA_XFER);
endmodule

// *** src/sdha_params.svh ***
// Purpose: Offsets, field positions and reset values of the ADMA data path
// Assumes: Word aligned register offsets on an 8-bit byte address
// Notes:   Included by the design modules; the package does not include it
`ifndef SDHA_PARAMS_SVH
`define SDHA_PARAMS_SVH
// Register byte offsets
`define SDHA_OFS_BLOCK_ATTRIBUTES_REGISTER   8'h04
`define SDHA_OFS_XFERCTL   8'h0c
`define SDHA_OFS_CMDCTL    8'h10
`define SDHA_OFS_PRSSTATE  8'h24
`define SDHA_OFS_INTERRUPT_STATUS_REGISTER   8'h30
`define SDHA_OFS_IRQMASK   8'h34
`define SDHA_OFS_FIFOLVL   8'h38
// Transfer control fields
`define SDHA_XC_START      0
`define SDHA_XC_BLOCK_COUNT_ENABLE       1
`define SDHA_XC_ADMA2      2
`define SDHA_XC_ABORT      3
`define SDHA_XC_WM_LSB     8
// Command control fields
`define SDHA_CC_ARM        8
// Present state fields
`define SDHA_PS_BUSY       0
`define SDHA_PS_DLA        2
`define SDHA_PS_DAT0       24
// Interrupt status fields
`define SDHA_IS_TC         0
`define SDHA_IS_CRC        1
`define SDHA_IS_IDX        2
`define SDHA_IS_RESP       3
// Reset values
`define SDHA_RST_BLOCK_ATTRIBUTES_REGISTER   32'h0001_0200
`define SDHA_RST_WM        4'h1
// Response frame and data word size
`define SDHA_RESP_BITS     6'd48
`define SDHA_WORD_BYTES    17'd4
`endif

// *** src/sdha_pkg.sv ***
// Purpose: Types shared by the ADMA data path modules
// Assumes: Constants live in sdha_params.svh
// Notes:   Nothing here is imported; users write sdha_pkg::name
package sdha_pkg;
    // Descriptor word as handed over by the descriptor fetcher
    typedef struct packed {
        logic [15:0] len;
        logic [9:0]  rsv_hi;
        logic [1:0]  act;
        logic        rsv_lo;
        logic        intr;
        logic        last;
        logic        valid;
    } sdha_desc_t;

    // Descriptor actions
    typedef enum logic [1:0] {
        SDHA_ACT_NOP  = 2'h0,
        SDHA_ACT_RSV  = 2'h1,
        SDHA_ACT_TRAN = 2'h2,
        SDHA_ACT_LINK = 2'h3
    } sdha_act_t;

    // Data path states, Gray coded along the usual path
    typedef enum logic [2:0] {
        SDHA_IDLE  = 3'h0,
        SDHA_FETCH = 3'h1,
        SDHA_XFER  = 3'h3,
        SDHA_WTC   = 3'h2
    } sdha_state_t;
endpackage

// *** src/sdha_resp_chk.sv ***
// Purpose: Command response framing, index and CRC7 check
// Assumes: bit_en pulses once per card clock rising edge
// Notes:   Runs independently of the data path
`timescale 1ns/1ps
`include "sdha_params.svh"
module sdha_resp_chk (
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic       bit_en,
    input  wire logic       cmd_bit,
    input  wire logic       arm,
    input  wire logic [5:0] exp_index,
    output logic            done,
    output logic            crc_err,
    output logic            idx_err
);
    typedef struct packed {
        logic        armed;
        logic        busy;
        logic [5:0]  cnt;
        logic [47:0] sh;
        logic        done;
        logic        crc_err;
        logic        idx_err;
    } sdha_chk_t;

    sdha_chk_t s_reg, s_next;

    // CRC7 over the first forty response bits
    function automatic logic [6:0] sdha_crc7(input logic [39:0] d);
        logic [6:0] c;
        logic       fb;
        c = 7'h00;
        for (int i = 39; i >= 0; i--) begin
            fb = d[i] ^ c[6];
            c = {c[5:0], 1'b0};
            if (fb) begin
                c = c ^ 7'h09;
            end
        end
        return c;
    endfunction

    // Wait for start bit, gather the frame, check it
    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        s_next.crc_err = 1'b0;
        s_next.idx_err = 1'b0;
        if (arm) begin
            s_next.armed = 1'b1;
        end
        if (bit_en) begin
            if (!s_reg.busy && s_reg.armed && !cmd_bit) begin
                s_next.busy = 1'b1;
                s_next.cnt = 6'd1;
                s_next.sh = 48'h0;
            end else if (s_reg.busy) begin
                s_next.sh = {s_reg.sh[46:0], cmd_bit};
                s_next.cnt = s_reg.cnt + 6'd1;
                if (s_reg.cnt == `SDHA_RESP_BITS - 6'd1) begin
                    s_next.busy = 1'b0;
                    s_next.armed = arm;
                    s_next.done = 1'b1;
                    // Flag both mismatches
                    s_next.crc_err = sdha_crc7(s_reg.sh[46:7])
                                     != s_reg.sh[6:0];
                    s_next.idx_err = s_reg.sh[44:39] != exp_index;
                end
            end
        end
    end

    // State register
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign done    = s_reg.done;
    assign crc_err = s_reg.crc_err;
    assign idx_err = s_reg.idx_err;

    a_err_with_done: assert property (
        @(posedge clock) disable iff (!rst_b)
        (crc_err || idx_err) |-> done)
        else $error("Response error flagged without frame end");
endmodule

// *** test/sdha_card_model.sv ***
// Purpose: Card model driving the card clock, command and DAT0 pins
// Assumes: Card pull-ups hold CMD and DAT0 high while released
// Notes:   Clock runs only inside frames, 200 ns period
`timescale 1ns/1ps
module sdha_card_model (
    output logic sd_clk,
    output logic sd_cmd,
    output logic sd_dat0
);
    logic [47:0] frm;

    // CRC7 with polynomial 0x09 over the first 40 frame bits
    function automatic logic [6:0] crc7(input logic [39:0] b);
        logic [6:0] c;
        logic       f;
        c = 7'h00;
        for (int i = 39; i >= 0; i--) begin
            f = b[i] ^ c[6];
            c = {c[5:0], 1'b0} ^ (f ? 7'h09 : 7'h00);
        end
        return c;
    endfunction

    // Idle pins: clock still, lines at pull-up level
    initial begin
        sd_clk = 1'b0;
        sd_cmd = 1'b1;
        sd_dat0 = 1'b1;
    end

    // Hold DAT0 at a level, low while the card signals busy
    task automatic hold(input logic v);
        sd_dat0 = v;
    endtask

    // Send nd data bits MSB first; a response starts at bit 8 when on
    task automatic run(input logic [95:0] dat, input int nd,
                       input logic [5:0] idx, input logic bad,
                       input logic on);
        logic [39:0] hd;
        int          n;
        hd = {2'b00, idx, 32'h0000_0a5a};
        frm = {hd, crc7(hd) ^ {6'h00, bad}, 1'b1};
        n = (on && nd < 56) ? 56 : nd;
        for (int i = 0; i < n; i++) begin
            sd_dat0 = (i < nd) ? dat[95 - i] : 1'b1;
            sd_cmd = (on && i >= 8 && i < 56) ? frm[55 - i] : 1'b1;
            #100 sd_clk = 1'b1;
            #100 sd_clk = 1'b0;
        end
        sd_dat0 = 1'b1;
        sd_cmd = 1'b1;
    endtask
endmodule

// *** test/sdha_core_tb.sv ***
// Purpose: Self-checking bench for the ADMA read data path
// Assumes: Bus side accepts FIFO words except while the first transfer holds it off
// Notes:   Descriptors are served from a queue loaded before start
`timescale 1ns/1ps
module sdha_core_tb;
    logic        clock;
    logic        rst_b;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        desc_valid;
    logic [31:0] desc_data;
    logic        desc_ready;
    logic        dma_valid;
    logic        dma_ready;
    logic [31:0] dma_data;
    logic        sd_clk;
    logic        sd_cmd;
    logic        sd_dat0;
    logic        fifo_clk_en;
    logic        irq;
    logic [31:0] dq[$];
    logic [31:0] rx[$];
    logic [31:0] v;
    int          bad_count;
    int          checks;

    sdha_core sdha_core_inst (.clock(clock), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .desc_valid(desc_valid),
        .desc_data(desc_data), .desc_ready(desc_ready),
        .dma_valid(dma_valid), .dma_ready(dma_ready), .dma_data(dma_data),
        .sd_clk(sd_clk), .sd_cmd(sd_cmd), .sd_dat0(sd_dat0),
        .fifo_clk_en(fifo_clk_en), .irq(irq));
    sdha_card_model sdha_card_model_inst (.sd_clk(sd_clk),
        .sd_cmd(sd_cmd), .sd_dat0(sd_dat0));

    // 40 MHz clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // Descriptor server and FIFO word collector
    always @(posedge clock) begin
        if (desc_valid && desc_ready) begin
            void'(dq.pop_front());
        end
        desc_valid <= (dq.size() != 0);
        desc_data <= (dq.size() != 0) ? dq[0] : 32'h0000_0000;
        if (dma_valid && dma_ready) begin
            rx.push_back(dma_data);
        end
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR %0t: got %h want %h", $time, s, e);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    // Read data stand in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        chk(d, e);
    endtask

    // Poll transfer complete with a bounded count
    task automatic wait_tc;
        logic [31:0] d;
        for (int i = 0; i < 60; i++) begin
            rd(8'h30, d);
            if (d[0] === 1'b1) begin
                return;
            end
        end
        bad_count++;
        $display("ERROR %0t: transfer complete never seen", $time);
        stop_test();
    endtask

    // Compare collected words with the sent ones
    task automatic chk_rx(input logic [95:0] w, input int n);
        chk(rx.size(), n);
        for (int i = 0; i < n && i < rx.size(); i++) begin
            chk(rx[i], w[95 - 32 * i -: 32]);
        end
        rx.delete();
    endtask

    // Main sequence
    initial begin
        rst_b = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        dma_ready = 1'b1;
        bad_count = 0;
        checks = 0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        repeat (4) @(posedge clock);
        #1 chk({28'h0, irq, fifo_clk_en, desc_ready, dma_valid},
               32'h0);
        rdc(8'h04, 32'h0001_0200);
        rdc(8'h0c, 32'h0000_0100);
        rdc(8'h24, 32'h0100_0000);
        rdc(8'h34, 32'h0000_0000);
        wr(8'h50, 32'hffff_ffff);
        rdc(8'h50, 32'h0000_0000);
        // Long transfer setting: counting on, maximum block count
        wr(8'h04, 32'hffff_0200);
        rdc(8'h04, 32'hffff_0200);
        wr(8'h0c, 32'h0000_0002);
        rdc(8'h0c, 32'h0000_0002);
        // Card busy pulls DAT0 low
        sdha_card_model_inst.hold(1'b0);
        repeat (5) @(posedge clock);
        rdc(8'h24, 32'h0000_0001);
        sdha_card_model_inst.hold(1'b1);
        // Two words, one block, counting off, response during data
        wr(8'h04, 32'h0001_0008);
        dq.push_back(32'h0008_0023);
        wr(8'h10, 32'h0000_0103);
        wr(8'h0c, 32'h0000_0101);
        // Bus side holds off so the FIFO keeps both words
        dma_ready <= 1'b0;
        rdc(8'h24, 32'h0100_0004);
        sdha_card_model_inst.run({96'h1234_5678_9abc_def0_0000_0000},
                                 64, 6'h03, 1'b0, 1'b1);
        rdc(8'h38, 32'h0000_0002);
        chk({30'h0, fifo_clk_en, dma_valid}, 32'h3);
        @(posedge clock);
        dma_ready <= 1'b1;
        wait_tc();
        chk_rx(96'h1234_5678_9abc_def0_0000_0000, 2);
        rdc(8'h30, 32'h0000_0009);
        chk({31'h0, irq}, 32'h0);
        wr(8'h34, 32'h0000_0001);
        @(posedge clock);
        #1 chk({31'h0, irq}, 32'h1);
        wr(8'h30, 32'h0000_000f);
        @(posedge clock);
        #1 chk({31'h0, irq}, 32'h0);
        rdc(8'h30, 32'h0000_0000);
        // Counting on, NOP, short TRANS, wrong response index
        wr(8'h04, 32'h0003_0004);
        dq.push_back(32'h0000_0001);
        dq.push_back(32'h0003_0021);
        dq.push_back(32'h0008_0023);
        wr(8'h10, 32'h0000_0105);
        wr(8'h0c, 32'h0000_0103);
        sdha_card_model_inst.run(96'hcafe_0001_5555_aaaa_0f0f_f0f0,
                                 96, 6'h06, 1'b0, 1'b1);
        wait_tc();
        chk_rx(96'hcafe_0001_5555_aaaa_0f0f_f0f0, 3);
        rdc(8'h30, 32'h0000_000d);
        rdc(8'h24, 32'h0100_0000);
        rdc(8'h04, 32'h0000_0004);
        wr(8'h30, 32'h0000_000f);
        // Unaligned block size stalls, bad CRC, abort exits
        wr(8'h04, 32'h0001_0006);
        dq.push_back(32'h0008_0023);
        wr(8'h10, 32'h0000_0102);
        wr(8'h0c, 32'h0000_0105);
        sdha_card_model_inst.run(96'h0bad_f00d_7777_1111_0000_0000,
                                 64, 6'h02, 1'b1, 1'b1);
        repeat (40) @(posedge clock);
        chk_rx(96'h0bad_f00d_7777_1111_0000_0000, 2);
        rdc(8'h30, 32'h0000_000a);
        rdc(8'h24, 32'h0100_0004);
        rdc(8'h0c, 32'h0000_0104);
        wr(8'h0c, 32'h0000_0008);
        rdc(8'h24, 32'h0100_0000);
        rd(8'h30, v);
        chk(v, 32'h0000_000a);
        // Same command again after the CRC error, now clean
        wr(8'h30, 32'h0000_000f);
        wr(8'h10, 32'h0000_0102);
        sdha_card_model_inst.run(96'h0, 0, 6'h02, 1'b0, 1'b1);
        rdc(8'h30, 32'h0000_0008);
        stop_test();
    end
endmodule
